// ### cfg_space_pkg.sv
// Constants for the configuration header register bank
package cfg_space_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_IDENTITY   = 8'h00;
  localparam logic [7:0] OFF_CMD_STS    = 8'h04;
  localparam logic [7:0] OFF_CLASS_REV  = 8'h08;
  localparam logic [7:0] OFF_LAT_LINE   = 8'h0c;
  localparam logic [7:0] OFF_IO_BASE    = 8'h10;
  localparam logic [7:0] OFF_MEM_BASE   = 8'h14;
  localparam logic [7:0] OFF_SUBSYS     = 8'h2c;
  localparam logic [7:0] OFF_ROM_BASE   = 8'h30;
  localparam logic [7:0] OFF_CAP_HEAD   = 8'h34;
  localparam logic [7:0] OFF_INT_LAT    = 8'h3c;
  localparam logic [7:0] OFF_SCRATCH    = 8'h40;
  localparam logic [7:0] OFF_MARKER     = 8'h80;
  localparam logic [7:0] OFF_PM_CAP     = 8'hc0;
  localparam logic [7:0] OFF_PM_CTRL    = 8'hc4;

  // ----------------------------------------------------------------
  // Writable bit masks and write-one-to-clear masks
  // ----------------------------------------------------------------
  localparam logic [31:0] CMD_STS_WMASK  = 32'h0000_0147;
  localparam logic [31:0] CMD_STS_W1C    = 32'hf100_0000;
  localparam logic [31:0] LAT_LINE_WMASK = 32'h0000_ffff;
  localparam logic [31:0] IO_BASE_WMASK  = 32'hffff_ff80;
  localparam logic [31:0] MEM_BASE_WMASK = 32'hffff_ff80;
  localparam logic [31:0] ROM_BASE_WMASK = 32'hfffe_0001;
  localparam logic [31:0] INT_LAT_WMASK  = 32'h0000_00ff;
  localparam logic [31:0] SCRATCH_WMASK  = 32'h0000_ff00;
  localparam logic [31:0] PM_CTRL_WMASK  = 32'h0000_0103;
  localparam logic [31:0] PM_CTRL_W1C    = 32'h0000_8000;

  // ----------------------------------------------------------------
  // Fixed fields and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] STS_FIXED      = 16'h0290;
  localparam logic [15:0] CMD_RESET      = 16'h0100;
  localparam logic [7:0]  LAT_RESET      = 8'h00;
  localparam logic [7:0]  LINE_RESET     = 8'h00;
  localparam logic        IO_SPACE_FLAG  = 1'b1;
  localparam logic [7:0]  CAP_PTR        = 8'hc0;
  localparam logic [7:0]  PM_CAP_KIND    = 8'h01;
  localparam logic [7:0]  PM_NEXT_ITEM   = 8'h00;
  localparam logic [7:0]  INT_PIN_VALUE  = 8'h01;
  localparam logic [7:0]  INT_LINE_RESET = 8'h00;
  localparam logic [7:0]  SCRATCH_RESET  = 8'h00;
  localparam logic [1:0]  PM_STATE_RESET = 2'h0;

  // Window sizes as low address bits that are not decoded
  localparam int IO_WINDOW_BITS  = 7;
  localparam int MEM_WINDOW_BITS = 7;
  localparam int ROM_WINDOW_BITS = 17;

endpackage

// ### cfg_id_loader.sv
// Captures identity and latency fields from the serial memory reader after reset
`timescale 1ns/1ps

module cfg_id_loader (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  output logic             load_req,
  input  wire logic        load_valid,
  input  wire logic [15:0] load_device_id,
  input  wire logic [15:0] load_vendor_id,
  input  wire logic [15:0] load_subsys_id,
  input  wire logic [15:0] load_subsys_vendor_id,
  input  wire logic [7:0]  load_max_lat,
  input  wire logic [7:0]  load_min_gnt,
  output logic [31:0]      identity,
  output logic [31:0]      subsys,
  output logic [15:0]      lat_gnt,
  output logic             loaded
);

  typedef struct packed {
    logic        req;
    logic        done;
    logic [31:0] identity;
    logic [31:0] subsys;
    logic [15:0] lat_gnt;
  } loader_state_t;

  loader_state_t state;
  loader_state_t next_state;

  // ----------------------------------------------------------------
  // Reload sequence
  // ----------------------------------------------------------------

  // Request once after reset release, capture the single answer
  always_comb begin
    next_state = state;
    if (!state.done) begin
      next_state.req = 1'b1;
    end
    if (state.req && load_valid) begin
      next_state.identity = {load_device_id, load_vendor_id};
      next_state.subsys   = {load_subsys_id, load_subsys_vendor_id};
      next_state.lat_gnt  = {load_max_lat, load_min_gnt};
      next_state.req      = 1'b0;
      next_state.done     = 1'b1;
    end
  end

  // Hardware reset clears the loaded values until the reload completes
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign load_req = state.req;
  assign identity = state.identity;
  assign subsys   = state.subsys;
  assign lat_gnt  = state.lat_gnt;
  assign loaded   = state.done;

endmodule

// ### cfg_space_bank.sv
// Configuration header register bank reached over APB
`timescale 1ns/1ps

module cfg_space_bank #(
  parameter logic [31:0] CHIP_MARKER    = 32'h1234_5678, // Arbitrary value
  parameter logic [7:0]  BASE_CLASS     = 8'h02,
  parameter logic [7:0]  SUB_CLASS      = 8'h00,
  parameter logic [7:0]  REVISION_STEP  = 8'h11,
  parameter logic [15:0] PM_CAP_BITS    = 16'h0002
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             load_req,
  input  wire logic        load_valid,
  input  wire logic [15:0] load_device_id,
  input  wire logic [15:0] load_vendor_id,
  input  wire logic [15:0] load_subsys_id,
  input  wire logic [15:0] load_subsys_vendor_id,
  input  wire logic [7:0]  load_max_lat,
  input  wire logic [7:0]  load_min_gnt,
  input  wire logic        evt_parity_err,
  input  wire logic        evt_sys_err,
  input  wire logic        evt_master_abort,
  input  wire logic        evt_target_abort,
  input  wire logic        evt_data_parity,
  input  wire logic        evt_pme,
  output logic [15:0]      command,
  output logic [31:0]      io_window_base,
  output logic [31:0]      memory_window_base,
  output logic [31:0]      boot_rom_window_base,
  output logic [1:0]       power_state,
  output logic             ids_loaded
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] command;
    logic [4:0]  sts_err;   // 31,30,29,28,24
    logic [7:0]  latency;
    logic [7:0]  line_size;
    logic [24:0] io_base;
    logic [24:0] mem_base;
    logic [14:0] rom_base;
    logic        rom_en;
    logic [7:0]  int_line;
    logic [7:0]  scratch;
    logic [1:0]  pm_state;
    logic        pme_en;
    logic        pme_sts;
    logic [31:0] prdata;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  logic [31:0] id_word;
  logic [31:0] subsys_word;
  logic [15:0] lat_gnt;
  logic        wr_en;
  logic [31:0] sts_cmd_word;
  logic [31:0] lat_line_word;
  logic [31:0] io_word;
  logic [31:0] mem_word;
  logic [31:0] rom_word;
  logic [31:0] int_word;
  logic [31:0] scratch_word;
  logic [31:0] pm_word;
  logic [31:0] merged;
  logic [31:0] clear_bits;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Expand byte strobes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Replace writable bits inside enabled lanes only
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m     = lane_mask(strb) & wmask;
    merge = (cur & ~m) | (wd & m);
  endfunction

  // ----------------------------------------------------------------
  // Reload of identity fields
  // ----------------------------------------------------------------

  // Serial memory values land here after each hardware reset
  cfg_id_loader u_loader (
    .mclk                  (mclk),
    .reset_n               (reset_n),
    .load_req              (load_req),
    .load_valid            (load_valid),
    .load_device_id        (load_device_id),
    .load_vendor_id        (load_vendor_id),
    .load_subsys_id        (load_subsys_id),
    .load_subsys_vendor_id (load_subsys_vendor_id),
    .load_max_lat          (load_max_lat),
    .load_min_gnt          (load_min_gnt),
    .identity              (id_word),
    .subsys                (subsys_word),
    .lat_gnt               (lat_gnt),
    .loaded                (ids_loaded)
  );

  // ----------------------------------------------------------------
  // Register word images
  // ----------------------------------------------------------------

  // Assemble each word as software sees it
  assign sts_cmd_word  = {state.sts_err[4:1], 1'b0, cfg_space_pkg::STS_FIXED[10:9],
                          state.sts_err[0], cfg_space_pkg::STS_FIXED[7:0],
                          state.command};
  assign lat_line_word = {16'h0000, state.latency, state.line_size};
  assign io_word       = {state.io_base, 6'h00, cfg_space_pkg::IO_SPACE_FLAG};
  assign mem_word      = {state.mem_base, 7'h00};
  assign rom_word      = {state.rom_base, 16'h0000, state.rom_en};
  assign int_word      = {lat_gnt, cfg_space_pkg::INT_PIN_VALUE, state.int_line};
  assign scratch_word  = {16'h0000, state.scratch, 8'h00};
  assign pm_word       = {16'h0000, state.pme_sts, 6'h00, state.pme_en, 6'h00,
                          state.pm_state};

  // Read decode; unlisted offsets read zero
  function automatic logic [31:0] read_word(input logic [7:0] a);
    case ({a[7:2], 2'b00})
      cfg_space_pkg::OFF_IDENTITY:  read_word = id_word;
      cfg_space_pkg::OFF_CMD_STS:   read_word = sts_cmd_word;
      cfg_space_pkg::OFF_CLASS_REV: read_word = {BASE_CLASS, SUB_CLASS, 8'h00,
                                                 REVISION_STEP};
      cfg_space_pkg::OFF_LAT_LINE:  read_word = lat_line_word;
      cfg_space_pkg::OFF_IO_BASE:   read_word = io_word;
      cfg_space_pkg::OFF_MEM_BASE:  read_word = mem_word;
      cfg_space_pkg::OFF_SUBSYS:    read_word = subsys_word;
      cfg_space_pkg::OFF_ROM_BASE:  read_word = rom_word;
      cfg_space_pkg::OFF_CAP_HEAD:  read_word = {24'h000000, cfg_space_pkg::CAP_PTR};
      cfg_space_pkg::OFF_INT_LAT:   read_word = int_word;
      cfg_space_pkg::OFF_SCRATCH:   read_word = scratch_word;
      cfg_space_pkg::OFF_MARKER:    read_word = CHIP_MARKER;
      cfg_space_pkg::OFF_PM_CAP:    read_word = {PM_CAP_BITS, cfg_space_pkg::PM_NEXT_ITEM,
                                                 cfg_space_pkg::PM_CAP_KIND};
      cfg_space_pkg::OFF_PM_CTRL:   read_word = pm_word;
      default:                      read_word = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------

  // Read data is captured in the setup cycle, so the access phase ends at once
  assign pready  = psel & penable;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;

  // Next state: hardware events set, bus writes merge by lane
  always_comb begin
    next_state = state;
    merged     = 32'h0000_0000;
    clear_bits = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      next_state.prdata = read_word(paddr);
    end
    if (wr_en) begin
      case ({paddr[7:2], 2'b00})
        cfg_space_pkg::OFF_CMD_STS: begin
          merged     = merge(sts_cmd_word, pwdata, pstrb, cfg_space_pkg::CMD_STS_WMASK);
          clear_bits = pwdata & lane_mask(pstrb) & cfg_space_pkg::CMD_STS_W1C;
          next_state.command = merged[15:0];
          next_state.sts_err = state.sts_err & ~{clear_bits[31:28], clear_bits[24]};
        end
        cfg_space_pkg::OFF_LAT_LINE: begin
          merged = merge(lat_line_word, pwdata, pstrb, cfg_space_pkg::LAT_LINE_WMASK);
          next_state.latency   = merged[15:8];
          next_state.line_size = merged[7:0];
        end
        cfg_space_pkg::OFF_IO_BASE: begin
          merged = merge(io_word, pwdata, pstrb, cfg_space_pkg::IO_BASE_WMASK);
          next_state.io_base = merged[31:7];
        end
        cfg_space_pkg::OFF_MEM_BASE: begin
          merged = merge(mem_word, pwdata, pstrb, cfg_space_pkg::MEM_BASE_WMASK);
          next_state.mem_base = merged[31:7];
        end
        cfg_space_pkg::OFF_ROM_BASE: begin
          merged = merge(rom_word, pwdata, pstrb, cfg_space_pkg::ROM_BASE_WMASK);
          next_state.rom_base = merged[31:17];
          next_state.rom_en   = merged[0];
        end
        cfg_space_pkg::OFF_INT_LAT: begin
          merged = merge(int_word, pwdata, pstrb, cfg_space_pkg::INT_LAT_WMASK);
          next_state.int_line = merged[7:0];
        end
        cfg_space_pkg::OFF_SCRATCH: begin
          merged = merge(scratch_word, pwdata, pstrb, cfg_space_pkg::SCRATCH_WMASK);
          next_state.scratch = merged[15:8];
        end
        cfg_space_pkg::OFF_PM_CTRL: begin
          merged     = merge(pm_word, pwdata, pstrb, cfg_space_pkg::PM_CTRL_WMASK);
          clear_bits = pwdata & lane_mask(pstrb) & cfg_space_pkg::PM_CTRL_W1C;
          next_state.pm_state = merged[1:0];
          next_state.pme_en   = merged[8];
          next_state.pme_sts  = state.pme_sts & ~clear_bits[15];
        end
        default: begin
          next_state.command = state.command;
        end
      endcase
    end
    // Events are applied last so a set wins over a clear in the same cycle
    next_state.sts_err = next_state.sts_err | {evt_parity_err, evt_sys_err,
                                               evt_master_abort, evt_target_abort,
                                               evt_data_parity};
    next_state.pme_sts = next_state.pme_sts | evt_pme;
  end

  // Only the hardware reset input restores defaults; no other reset exists here
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state           <= '0;
      state.command   <= cfg_space_pkg::CMD_RESET;
      state.latency   <= cfg_space_pkg::LAT_RESET;
      state.line_size <= cfg_space_pkg::LINE_RESET;
      state.int_line  <= cfg_space_pkg::INT_LINE_RESET;
      state.scratch   <= cfg_space_pkg::SCRATCH_RESET;
      state.pm_state  <= cfg_space_pkg::PM_STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs to the rest of the controller
  assign prdata               = state.prdata;
  assign command              = state.command;
  assign io_window_base       = io_word & cfg_space_pkg::IO_BASE_WMASK;
  assign memory_window_base   = mem_word;
  assign boot_rom_window_base = {state.rom_base, 17'h00000};
  assign power_state          = state.pm_state;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_defaults;
    @(posedge mclk) !reset_n |=> (command == cfg_space_pkg::CMD_RESET && power_state == 2'h0);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("defaults not restored by reset");

  property p_read_identity;
    @(posedge mclk) disable iff (!reset_n)
      (psel && !penable && !pwrite && paddr[7:2] == 6'h00) |=> (prdata == $past(id_word));
  endproperty
  a_read_identity: assert property (p_read_identity)
    else $error("identity word read wrong");

  property p_marker_fixed;
    @(posedge mclk) disable iff (!reset_n)
      (psel && !penable && !pwrite && paddr[7:2] == 6'h20) |=> (prdata == CHIP_MARKER);
  endproperty
  a_marker_fixed: assert property (p_marker_fixed)
    else $error("marker word not constant");

  property p_reserved_zero;
    @(posedge mclk) disable iff (!reset_n)
      (psel && !penable && !pwrite && paddr[7:2] >= 6'h06 && paddr[7:2] <= 6'h0a)
      |=> (prdata == 32'h0000_0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved offset read nonzero");

  property p_scratch_write;
    @(posedge mclk) disable iff (!reset_n)
      (wr_en && paddr[7:2] == 6'h10 && pstrb[1]) |=> (state.scratch == $past(pwdata[15:8]));
  endproperty
  a_scratch_write: assert property (p_scratch_write)
    else $error("scratch byte not stored");

  property p_lane_respected;
    @(posedge mclk) disable iff (!reset_n)
      (wr_en && paddr[7:2] == 6'h03 && !pstrb[1]) |=> $stable(state.latency);
  endproperty
  a_lane_respected: assert property (p_lane_respected)
    else $error("disabled lane was written");

  property p_event_wins;
    @(posedge mclk) disable iff (!reset_n) evt_parity_err |=> sts_cmd_word[31] [*2];
  endproperty
  a_event_wins: assert property (p_event_wins)
    else $error("status bit lost after event");

  property p_rom_window;
    @(posedge mclk) disable iff (!reset_n)
      (wr_en && paddr[7:2] == 6'h0c && pstrb == 4'hf)
      |=> (boot_rom_window_base == ($past(pwdata) & 32'hfffe_0000));
  endproperty
  a_rom_window: assert property (p_rom_window)
    else $error("rom window not 128KB aligned");

  property p_reload_hold;
    @(posedge mclk) disable iff (!reset_n)
      ids_loaded |=> (ids_loaded && $stable(id_word) && !load_req);
  endproperty
  a_reload_hold: assert property (p_reload_hold)
    else $error("loaded identity changed");

  // Full-word command writes keep only the writable command bits
  property p_cmd_write;
    @(posedge mclk) disable iff (!reset_n)
      (wr_en && paddr[7:2] == 6'h01 && pstrb == 4'hf)
      |=> (command == ($past(pwdata[15:0]) & cfg_space_pkg::CMD_STS_WMASK[15:0]));
  endproperty
  a_cmd_write: assert property (p_cmd_write)
    else $error("command half not written as masked");

  // Power state field follows a write of its lane
  property p_power_write;
    @(posedge mclk) disable iff (!reset_n)
      (wr_en && paddr[7:2] == 6'h31 && pstrb[0]) |=> (power_state == $past(pwdata[1:0]));
  endproperty
  a_power_write: assert property (p_power_write)
    else $error("power state not written");

  // Wake event status bit is set on the edge after the event
  property p_pme_set;
    @(posedge mclk) disable iff (!reset_n) evt_pme |=> pm_word[15];
  endproperty
  a_pme_set: assert property (p_pme_set)
    else $error("wake status bit not set by event");

endmodule

// ### serial_id_source.sv
// Model of the serial memory reader that hands identity fields to the bank
`timescale 1ns/1ps

module serial_id_source #(
  parameter logic [15:0] DEV_ID = 16'h5a01, // Arbitrary value
  parameter logic [15:0] VEN_ID = 16'h3c02, // Arbitrary value
  parameter logic [15:0] SS_ID  = 16'h7e03, // Arbitrary value
  parameter logic [15:0] SSV_ID = 16'h1b04, // Arbitrary value
  parameter logic [7:0]  MAX_LAT = 8'h28,
  parameter logic [7:0]  MIN_GNT = 8'h0a
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        load_req,
  input  wire logic [3:0]  delay,
  output logic             load_valid,
  output logic [15:0]      load_device_id,
  output logic [15:0]      load_vendor_id,
  output logic [15:0]      load_subsys_id,
  output logic [15:0]      load_subsys_vendor_id,
  output logic [7:0]       load_max_lat,
  output logic [7:0]       load_min_gnt
);
  logic [3:0] wait_cnt;

  // One pulse per request, after a programmable number of cycles
  always_ff @(posedge mclk) begin
    load_valid <= 1'b0;
    if (!reset_n) begin
      wait_cnt <= 4'h0;
    end else if (load_req && !load_valid) begin
      if (wait_cnt == delay) begin
        load_valid <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end

  // Outside the pulse the fields carry inverted, useless values
  assign load_device_id        = load_valid ? DEV_ID : ~DEV_ID;
  assign load_vendor_id        = load_valid ? VEN_ID : ~VEN_ID;
  assign load_subsys_id        = load_valid ? SS_ID : ~SS_ID;
  assign load_subsys_vendor_id = load_valid ? SSV_ID : ~SSV_ID;
  assign load_max_lat          = load_valid ? MAX_LAT : ~MAX_LAT;
  assign load_min_gnt          = load_valid ? MIN_GNT : ~MIN_GNT;
endmodule

// ### testbench.sv
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ps

module testbench;
  // ------------------------------------------------------------
  // Signals and reference values
  // ------------------------------------------------------------
  localparam logic [31:0] MARKER = 32'h0bad_cafe; // Arbitrary value
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        load_req, load_valid, ids_loaded;
  logic [7:0]  paddr, a, max_lat, min_gnt;
  logic [31:0] pwdata, prdata, io_base, mem_base, rom_base, rd;
  logic [3:0]  pstrb, delay;
  logic [15:0] command, dev_id, ven_id, ss_id, ssv_id;
  logic [5:0]  evt;
  logic [1:0]  power_state;
  logic [31:0] shadow [256];
  int          error_cnt, n_checks;
  logic [7:0]  offs [21] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
    8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h80, 8'hc0, 8'hc4, 8'h50};
  int          ebit [6] = '{31, 30, 29, 28, 24, 15};

  cfg_space_bank #(.CHIP_MARKER(MARKER)) dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_req(load_req),
    .load_valid(load_valid), .load_device_id(dev_id), .load_vendor_id(ven_id),
    .load_subsys_id(ss_id), .load_subsys_vendor_id(ssv_id), .load_max_lat(max_lat),
    .load_min_gnt(min_gnt), .evt_parity_err(evt[0]), .evt_sys_err(evt[1]),
    .evt_master_abort(evt[2]), .evt_target_abort(evt[3]), .evt_data_parity(evt[4]),
    .evt_pme(evt[5]), .command(command), .io_window_base(io_base),
    .memory_window_base(mem_base), .boot_rom_window_base(rom_base),
    .power_state(power_state), .ids_loaded(ids_loaded));

  serial_id_source src (.mclk(mclk), .reset_n(reset_n), .load_req(load_req), .delay(delay),
    .load_valid(load_valid), .load_device_id(dev_id), .load_vendor_id(ven_id),
    .load_subsys_id(ss_id), .load_subsys_vendor_id(ssv_id), .load_max_lat(max_lat),
    .load_min_gnt(min_gnt));

  // ------------------------------------------------------------
  // Reference functions
  // ------------------------------------------------------------
  function automatic logic [31:0] reset_val(input logic [7:0] adr);
    case (adr)
      8'h00: return 32'h5a01_3c02;
      8'h04: return {cfg_space_pkg::STS_FIXED, cfg_space_pkg::CMD_RESET};
      8'h08: return 32'h0200_0011;
      8'h10: return 32'h0000_0001;
      8'h2c: return 32'h7e03_1b04;
      8'h34: return {24'h0, cfg_space_pkg::CAP_PTR};
      8'h3c: return {16'h280a, cfg_space_pkg::INT_PIN_VALUE, 8'h00};
      8'h80: return MARKER;
      8'hc0: return {16'h0002, cfg_space_pkg::PM_NEXT_ITEM, cfg_space_pkg::PM_CAP_KIND};
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] wmask(input logic [7:0] adr);
    case (adr)
      8'h04: return cfg_space_pkg::CMD_STS_WMASK;
      8'h0c: return cfg_space_pkg::LAT_LINE_WMASK;
      8'h10: return cfg_space_pkg::IO_BASE_WMASK;
      8'h14: return cfg_space_pkg::MEM_BASE_WMASK;
      8'h30: return cfg_space_pkg::ROM_BASE_WMASK;
      8'h3c: return cfg_space_pkg::INT_LAT_WMASK;
      8'h40: return cfg_space_pkg::SCRATCH_WMASK;
      8'hc4: return cfg_space_pkg::PM_CTRL_WMASK;
      default: return 32'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] adr, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= adr; pwdata <= d; pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check32({31'h0, pready}, 32'h1);
    check32({31'h0, pslverr}, 32'h0);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = wmask(adr) & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    apb(1'b1, adr, d, s, rd);
    shadow[adr] = (shadow[adr] & ~m) | (d & m);
  endtask

  task automatic check_reg(input logic [7:0] adr);
    apb(1'b0, adr, 32'h0, 4'h0, rd);
    check32(rd, shadow[adr]);
  endtask

  task automatic check_ports();
    check32({16'h0, command}, {16'h0, shadow[8'h04][15:0]});
    check32(io_base, shadow[8'h10] & cfg_space_pkg::IO_BASE_WMASK);
    check32(mem_base, shadow[8'h14] & cfg_space_pkg::MEM_BASE_WMASK);
    check32(rom_base, shadow[8'h30] & 32'hfffe_0000);
    check32({30'h0, power_state}, {30'h0, shadow[8'hc4][1:0]});
  endtask

  // Reset, wait for the identity reload, then rebuild the reference
  task automatic hw_reset(input int cycles);
    int n;
    n = 0;
    reset_n <= 1'b0;
    repeat (cycles) @(posedge mclk);
    reset_n <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (ids_loaded !== 1'b1 && n < 100);
    check32({31'h0, ids_loaded}, 32'h1);
    foreach (offs[i]) shadow[offs[i]] = reset_val(offs[i]);
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, pwdata, paddr, pstrb, evt} = '0;
    reset_n = 1'b0;
    delay = 4'h0;
    void'($urandom(8));
    hw_reset(20);
    foreach (offs[i]) check_reg(offs[i]);
    check_ports();
    foreach (offs[i]) begin
      wr(offs[i], 32'hffff_ffff, 4'hf);
      check_reg(offs[i]);
    end
    repeat (80) begin
      a = offs[$urandom_range(0, 20)];
      wr(a, $urandom, 4'($urandom_range(0, 15)));
      check_reg(a);
      check_ports();
    end
    for (int i = 0; i < 6; i++) begin
      a = (i < 5) ? 8'h04 : 8'hc4;
      @(posedge mclk);
      evt <= 6'(1 << i);
      @(posedge mclk);
      evt <= '0;
      @(posedge mclk);
      apb(1'b0, a, 32'h0, 4'h0, rd);
      check32(rd, shadow[a] | (32'h1 << ebit[i]));
      wr(a, 32'h1 << ebit[i], 4'(1 << (ebit[i] / 8)));
      check_reg(a);
    end
    delay <= 4'h9;
    hw_reset(3);
    foreach (offs[i]) check_reg(offs[i]);
    check_ports();
    tally_and_finish();
  end
endmodule
